// [logic/adc_uart_pkg.sv]
/*
 * Shared constants and types for the converter's UART command block:
 * command patterns, configuration register layout, output code limits,
 * serial timing defaults and state encodings.
 * Assumes a single 25 MHz system clock and a 24-bit result path.
 */
`default_nettype none

package adc_uart_pkg;

   // ****************************************
   // Clock and serial timing
   // ****************************************
   localparam int CLK_NS = 40;
   localparam int DEFAULT_BIT_NS = 8680;
   localparam int DEFAULT_BIT_CYC = DEFAULT_BIT_NS / CLK_NS;
   localparam logic [3:0] FRAME_BITS = 4'h9;
   localparam logic [2:0] LAST_DATA_BIT = 3'h7;

   // ****************************************
   // Command bytes: value and compare mask
   // ****************************************
   localparam logic [7:0] CMD_RESET = 8'h06;
   localparam logic [7:0] CMD_START = 8'h08;
   localparam logic [7:0] CMD_SLEEP = 8'h02;
   localparam logic [7:0] CMD_RDATA = 8'h10;
   localparam logic [7:0] CMD_RD_REG = 8'h20;
   localparam logic [7:0] CMD_WR_REG = 8'h40;
   localparam logic [7:0] MASK_LOW_X = 8'hFE;
   localparam logic [7:0] MASK_NIBBLE = 8'hF0;
   // Register commands ignore both the address and the trailing bit
   localparam logic [7:0] MASK_ADDR = 8'hF0;
   localparam int ADDR_LSB = 1;

   // ****************************************
   // Configuration registers
   // ****************************************
   localparam int NUM_REGS = 5;
   localparam logic [2:0] REG_LAST = 3'h4;
   localparam logic [2:0] REG_MODE = 3'h1;
   localparam logic [2:0] REG_STATUS = 3'h2;
   localparam logic [2:0] REG_AUTO = 3'h3;
   localparam logic [2:0] REG_PIN = 3'h4;
   localparam int CONT_BIT = 3;
   localparam int FLAG_BIT = 7;
   localparam int CNT_EN_BIT = 6;
   localparam int AUTO_BIT = 0;
   localparam int PIN2_DIR_BIT = 6;
   localparam int PIN2_ROUTE_BIT = 3;
   localparam int PIN2_DAT_BIT = 2;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ****************************************
   // Result format
   // ****************************************
   localparam int RESULT_W = 24;
   localparam logic [23:0] CODE_MAX = 24'h7FFFFF;
   localparam logic [23:0] CODE_MIN = 24'h800000;
   localparam logic [2:0] RESULT_BYTES = 3'h3;
   localparam logic [2:0] RESULT_CNT_BYTES = 3'h4;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic start;
      logic filter_clear;
      logic sleep;
      logic continuous;
   } conv_ctl_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_MEAS = 3'b001,
      RX_START = 3'b010,
      RX_DATA = 3'b011,
      RX_STOP = 3'b100
   } rx_state_t;

   typedef enum logic [1:0] {
      PH_SYNC = 2'b00,
      PH_CMD = 2'b01,
      PH_WDATA = 2'b10
   } phase_t;

   typedef enum logic {
      TX_IDLE = 1'b0,
      TX_BIT = 1'b1
   } tx_state_t;

endpackage

`default_nettype wire

// [logic/byte_fifo.sv]
/*
 * Synchronous FIFO with valid/ready on both sides and a flush.
 * Assumes DEPTH is a power of two; one clock, async active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clock_i, // System clock
   input wire logic arst_n_i, // Async reset, active low
   input wire logic flush_i, // Drop all entries
   input wire logic in_valid_i, // Write request
   output logic in_ready_o, // Room available
   input wire logic [WIDTH-1:0] in_data_i, // Write data
   output logic out_valid_o, // Entry available
   input wire logic out_ready_i, // Read accept
   output logic [WIDTH-1:0] out_data_o // Head entry
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;

   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;

   assign in_ready_o = count != (AW+1)'(DEPTH);
   assign out_valid_o = count != '0;
   assign out_data_o = mem[rd_ptr];

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers wrap naturally because DEPTH is a power of two
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (flush_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
         rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule

`default_nettype wire

// [logic/adc_uart_readout.sv]
/*
 * Command interpreter and result readout for a 24-bit converter behind a
 * half-duplex 8-N-1 UART with auto-baud. Holds the five config registers,
 * drives conversion control, queues reply bytes through a 16-entry FIFO.
 * Assumes rx_i is synchronous to clock_i and the converter core reports
 * each finished result with a one-cycle conv_done_i.
 */
// Notes on behaviour
// - Result clips to 7FFFFFh and 800000h.
// - Reset command restores every default.
// - Single-shot start; restart clears filter first.
// - Continuous start; repeat restarts with clear.
// - Sleep keeps registers, waits conversion end.
// - Start command wakes from sleep.
// - Read-result loads newest result, then sends.
// - Result arriving during load keeps flag set.
// - LSB first bits, least byte first.
// - Register read; missing address returns 00h.
// - Register write; missing address ignored.
// - Write except register 4 restarts conversion.
// - Baud measured from each sync byte.
// - Byte acted on at mid stop bit.
// - Tolerate stop detect timing jitter.
// - Auto mode sends each result unasked.
// - Flag reaches pin only if routed out.
// - Status bit shows unread result.
// - Transmission bytes frozen once loaded.
// - Optional counter counts each result.
// - Flag clears when result latched out.
`timescale 1ns/100ps
`default_nettype none

module adc_uart_readout #(
   parameter int RAW_W = 26,
   parameter int BAUD_W = 16,
   parameter int FIFO_DEPTH = 16,
   parameter int BIT_CYC = adc_uart_pkg::DEFAULT_BIT_CYC
) (
   input wire logic clock_i, // System clock, 25 MHz
   input wire logic arst_n_i, // Async reset, active low
   input wire logic rx_i, // UART receive from host
   output logic tx_o, // UART transmit to host
   output logic shared_flag_pin_o, // Pin 2 drive level
   output logic shared_flag_pin_oe_o, // Pin 2 drive enable
   input wire logic conv_done_i, // Result finished, pulse
   input wire logic conv_busy_i, // Conversion running
   input wire logic [RAW_W-1:0] conv_data_i, // Unclipped result
   output adc_uart_pkg::conv_ctl_t conv_ctl_o, // Conversion control
   output logic [adc_uart_pkg::NUM_REGS*8-1:0] cfg_o // Config registers
);
   import adc_uart_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   function automatic logic cmd_match(input logic [7:0] b,
                                      input logic [7:0] val,
                                      input logic [7:0] mask);
      cmd_match = (b & mask) == val;
   endfunction

   rx_state_t rx_st;
   phase_t ph;
   tx_state_t tx_st;
   logic [BAUD_W-1:0] period;
   logic [BAUD_W-1:0] tmr;
   logic [BAUD_W-1:0] meas;
   logic [2:0] bitn;
   logic [7:0] rx_byte;
   logic [2:0] wr_addr;
   logic soft_rst;
   logic [NUM_REGS-1:0][7:0] cfg;
   conv_ctl_t next_ctl;
   logic sleep_pending;
   logic [RESULT_W-1:0] result;
   logic [7:0] count;
   logic new_result_flag;
   logic auto_pend;
   logic [31:0] out_buf;
   logic [2:0] out_cnt;
   logic [BAUD_W-1:0] ttmr;
   logic [3:0] txn;
   logic [8:0] frame;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;

   // ****************************************
   // Output clipping and decode
   // ****************************************
   wire [RAW_W-RESULT_W:0] top_bits = conv_data_i[RAW_W-1:RESULT_W-1];
   wire fits = (top_bits == '0) || (&top_bits);
   wire [RESULT_W-1:0] clipped = fits ? conv_data_i[RESULT_W-1:0] :
                                 conv_data_i[RAW_W-1] ? CODE_MIN : CODE_MAX;

   wire byte_done = (rx_st == RX_STOP) && (tmr == '0) && rx_i;
   wire cmd_byte = byte_done && (ph == PH_CMD);
   wire wr_byte = byte_done && (ph == PH_WDATA);
   wire is_reset = cmd_byte && cmd_match(rx_byte, CMD_RESET, MASK_LOW_X);
   wire is_start = cmd_byte && cmd_match(rx_byte, CMD_START, MASK_LOW_X);
   wire is_sleep = cmd_byte && cmd_match(rx_byte, CMD_SLEEP, MASK_LOW_X);
   wire is_rdata = cmd_byte && cmd_match(rx_byte, CMD_RDATA, MASK_NIBBLE);
   wire is_rd_reg = cmd_byte && cmd_match(rx_byte, CMD_RD_REG, MASK_ADDR);
   wire is_wr_reg = cmd_byte && cmd_match(rx_byte, CMD_WR_REG, MASK_ADDR);
   wire [2:0] rd_addr = rx_byte[ADDR_LSB+2:ADDR_LSB];
   wire wr_hit = wr_byte && (wr_addr <= REG_LAST);
   wire restart_wr = wr_hit && (wr_addr != REG_PIN);

   wire continuous = cfg[REG_MODE][CONT_BIT];
   wire cnt_en = cfg[REG_STATUS][CNT_EN_BIT];
   wire auto_read = cfg[REG_AUTO][AUTO_BIT];
   wire pin2_direction = cfg[REG_PIN][PIN2_DIR_BIT];
   wire pin2_flag_route = cfg[REG_PIN][PIN2_ROUTE_BIT];

   // Status register shows the live flag in place of the stored bit
   wire [7:0] status_view = {new_result_flag, cfg[REG_STATUS][6:0]};
   wire [7:0] rd_val = (rd_addr > REG_LAST) ? UNMAPPED_READ :
                       (rd_addr == REG_STATUS) ? status_view :
                       cfg[rd_addr];

   // Only an idle loader accepts a new reply, so queued bytes never change
   wire load_result = (out_cnt == '0) && (is_rdata || auto_pend);
   wire load_reg = (out_cnt == '0) && is_rd_reg;
   wire [2:0] reply_len = cnt_en ? RESULT_CNT_BYTES : RESULT_BYTES;
   wire push = out_cnt != '0;
   wire pop = fifo_out_valid && (tx_st == TX_IDLE);

   // ****************************************
   // Receiver with auto-baud
   // ****************************************
   // Sampling at half the measured period leaves a few cycles of slack
   // either side, which covers the stop-detect jitter of the link.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_st <= RX_IDLE;
         period <= BAUD_W'(BIT_CYC);
         tmr <= '0;
         meas <= '0;
         bitn <= '0;
         rx_byte <= '0;
      end else if (soft_rst) begin
         rx_st <= RX_IDLE;
         period <= BAUD_W'(BIT_CYC);
         tmr <= '0;
      end else begin
         case (rx_st)
            RX_IDLE: begin
               meas <= BAUD_W'(1);
               tmr <= period >> 1;
               if (!rx_i) begin
                  // Sync start bit is exactly one bit long
                  rx_st <= (ph == PH_SYNC) ? RX_MEAS : RX_START;
               end
            end
            RX_MEAS: begin
               if (rx_i) begin
                  period <= meas;
                  tmr <= meas >> 1;
                  bitn <= '0;
                  rx_st <= RX_DATA;
               end else begin
                  meas <= meas + BAUD_W'(1);
               end
            end
            RX_START: begin
               if (tmr != '0) begin
                  tmr <= tmr - BAUD_W'(1);
               end else begin
                  tmr <= period - BAUD_W'(1);
                  bitn <= '0;
                  rx_st <= rx_i ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (tmr != '0) begin
                  tmr <= tmr - BAUD_W'(1);
               end else begin
                  rx_byte <= {rx_i, rx_byte[7:1]};
                  tmr <= period - BAUD_W'(1);
                  bitn <= bitn + 3'h1;
                  if (bitn == LAST_DATA_BIT) begin
                     rx_st <= RX_STOP;
                  end
               end
            end
            default: begin
               // Mid stop bit: a low here is a framing error, byte dropped
               if (tmr != '0) begin
                  tmr <= tmr - BAUD_W'(1);
               end else begin
                  rx_st <= RX_IDLE;
               end
            end
         endcase
      end
   end

   // ****************************************
   // Command sequencing and registers
   // ****************************************
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ph <= PH_SYNC;
         wr_addr <= '0;
         soft_rst <= 1'b0;
         cfg <= '0;
      end else if (soft_rst) begin
         ph <= PH_SYNC;
         soft_rst <= 1'b0;
         cfg <= '0;
      end else begin
         soft_rst <= is_reset;
         if (byte_done) begin
            case (ph)
               PH_SYNC: ph <= PH_CMD;
               PH_CMD: ph <= is_wr_reg ? PH_WDATA : PH_SYNC;
               default: ph <= PH_SYNC;
            endcase
         end
         if (is_wr_reg) begin
            wr_addr <= rd_addr;
         end
         if (wr_hit) begin
            cfg[wr_addr] <= rx_byte;
         end
      end
   end

   // ****************************************
   // Conversion control
   // ****************************************
   always_comb begin
      next_ctl = conv_ctl_o;
      next_ctl.continuous = continuous;
      next_ctl.start = is_start || (restart_wr && conv_busy_i);
      next_ctl.filter_clear = (is_start || restart_wr) && conv_busy_i;
      if (is_start) begin
         next_ctl.sleep = 1'b0;
      end else if (sleep_pending && !conv_busy_i) begin
         next_ctl.sleep = 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         conv_ctl_o <= '0;
         sleep_pending <= 1'b0;
      end else if (soft_rst) begin
         conv_ctl_o <= '0;
         sleep_pending <= 1'b0;
      end else begin
         conv_ctl_o <= next_ctl;
         sleep_pending <= !is_start && (is_sleep ||
                          (sleep_pending && conv_busy_i));
      end
   end

   // ****************************************
   // Result store, new-result flag and pin
   // ****************************************
   // A result landing as the old one is latched keeps the flag set
   wire next_flag = conv_done_i || (new_result_flag && !load_result);

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         result <= '0;
         count <= '0;
         new_result_flag <= 1'b0;
         auto_pend <= 1'b0;
         shared_flag_pin_o <= 1'b0;
         shared_flag_pin_oe_o <= 1'b0;
      end else if (soft_rst) begin
         result <= '0;
         count <= '0;
         new_result_flag <= 1'b0;
         auto_pend <= 1'b0;
         shared_flag_pin_o <= 1'b0;
         shared_flag_pin_oe_o <= 1'b0;
      end else begin
         if (conv_done_i) begin
            result <= clipped;
            count <= cnt_en ? count + 8'h01 : count;
         end
         new_result_flag <= next_flag;
         // Host must stay quiet while this reply streams out
         auto_pend <= (conv_done_i && auto_read) ||
                      (auto_pend && !load_result);
         shared_flag_pin_oe_o <= pin2_direction;
         shared_flag_pin_o <= (pin2_direction && pin2_flag_route) ?
                              !new_result_flag :
                              cfg[REG_PIN][PIN2_DAT_BIT];
      end
   end

   // ****************************************
   // Reply loader into the FIFO
   // ****************************************
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         out_buf <= '0;
         out_cnt <= '0;
      end else if (soft_rst) begin
         out_cnt <= '0;
      end else if (load_result) begin
         out_buf <= {count, result};
         out_cnt <= reply_len;
      end else if (load_reg) begin
         out_buf <= {24'h000000, rd_val};
         out_cnt <= 3'h1;
      end else if (push && fifo_in_ready) begin
         out_buf <= out_buf >> 8;
         out_cnt <= out_cnt - 3'h1;
      end
   end

   byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) reply_fifo (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .flush_i(soft_rst),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(out_buf[7:0]),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(tx_st == TX_IDLE),
      .out_data_o(fifo_out_data)
   );

   // ****************************************
   // Transmitter
   // ****************************************
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_st <= TX_IDLE;
         tx_o <= 1'b1;
         ttmr <= '0;
         txn <= '0;
         frame <= '0;
      end else if (soft_rst) begin
         tx_st <= TX_IDLE;
         tx_o <= 1'b1;
      end else if (tx_st == TX_IDLE) begin
         tx_o <= !pop;
         if (pop) begin
            frame <= {1'b1, fifo_out_data};
            ttmr <= period - BAUD_W'(1);
            txn <= '0;
            tx_st <= TX_BIT;
         end
      end else if (ttmr != '0) begin
         ttmr <= ttmr - BAUD_W'(1);
      end else if (txn == FRAME_BITS) begin
         tx_o <= 1'b1;
         tx_st <= TX_IDLE;
      end else begin
         tx_o <= frame[0];
         frame <= frame >> 1;
         txn <= txn + 4'h1;
         ttmr <= period - BAUD_W'(1);
      end
   end

   assign cfg_o = cfg;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   chk_clip_high: assert property (
      conv_done_i && !fits && !conv_data_i[RAW_W-1] && !soft_rst
      |=> result == CODE_MAX) else $error("positive overrange not clipped");
   // Soft reset flop rises one cycle late, its clear lands the cycle after
   chk_reset_all: assert property (
      is_reset |=> ##2 (cfg == '0) && !conv_ctl_o.sleep && ph == PH_SYNC)
      else $error("reset command left state");
   chk_start_clear: assert property (
      is_start && conv_busy_i |=> conv_ctl_o.start && conv_ctl_o.filter_clear)
      else $error("start while busy did not clear filter");
   chk_sleep_wait: assert property (
      sleep_pending && conv_busy_i && !is_start |=> !conv_ctl_o.sleep)
      else $error("sleep entered during conversion");
   chk_flag_kept: assert property (
      conv_done_i && !soft_rst |=> new_result_flag)
      else $error("fresh result flag lost");
   chk_flag_clear: assert property (
      load_result && !conv_done_i && !soft_rst |=> !new_result_flag)
      else $error("flag not cleared on latch");
   chk_read_unmapped: assert property (
      load_reg && rd_addr > REG_LAST && !soft_rst
      |=> out_buf[7:0] == UNMAPPED_READ && out_cnt == 3'h1)
      else $error("unmapped read not zero");
   chk_write_unmapped: assert property (
      wr_byte && wr_addr > REG_LAST && !soft_rst |=> cfg == $past(cfg))
      else $error("unmapped write changed registers");
   chk_sync_phase: assert property (
      byte_done && ph == PH_SYNC && !soft_rst |=> ph == PH_CMD)
      else $error("sync byte not taken");
   chk_pin_route: assert property (
      !pin2_flag_route && !soft_rst
      |=> shared_flag_pin_o == $past(cfg[REG_PIN][PIN2_DAT_BIT]))
      else $error("flag reached unrouted pin");
   chk_tx_idle: assert property (
      tx_st == TX_IDLE && $past(tx_st) == TX_IDLE |-> tx_o)
      else $error("transmit line low while idle");

   cov_rdata: cover property (is_rdata ##1 out_cnt != '0);
   cov_auto: cover property (conv_done_i && auto_read ##[1:4] load_result);
   cov_write: cover property (wr_hit && restart_wr);
   cov_sleep: cover property (is_sleep ##[1:50] conv_ctl_o.sleep);

endmodule

`default_nettype wire

// [tb/host_uart_model.sv]
/*
 * Host end of the two-wire UART. It sends framed bytes on the device
 * receive line and collects the reply bytes from the device transmit line.
 * Assumes that P matches the period the bench uses for every sync byte.
 */
`timescale 1ns/100ps
`default_nettype none
module host_uart_model #(
   parameter int P = 10
) (
   input wire logic clock_i, // System clock
   output logic rx_o, // Line to device receive
   input wire logic tx_i // Line from device transmit
);
   logic [7:0] rxq[$];
   initial rx_o = 1'b1;
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clock_i);
         rx_o <= f[i];
         repeat (P - 1) @(posedge clock_i);
      end
   endtask
   // A bad stop bit drops the byte, so framing slips show up as missing data
   always begin : collect
      logic [7:0] b;
      @(negedge tx_i);
      repeat (P / 2) @(posedge clock_i);
      for (int i = 0; i < 8; i++) begin
         repeat (P) @(posedge clock_i);
         b[i] = tx_i;
      end
      repeat (P) @(posedge clock_i);
      if (tx_i === 1'b1)
         rxq.push_back(b);
   end
endmodule
`default_nettype wire

// [tb/tb_adc_uart_readout.sv]
/*
 * Self-checking bench for the UART command block: register access,
 * result readout, auto mode, sleep, start and reset commands.
 * Assumes the host model runs at a period unlike the default one.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_adc_uart_readout;
   import adc_uart_pkg::*;
   localparam int P = 10;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic rx, tx, pin, pin_oe;
   logic done = 1'b0;
   logic busy = 1'b0;
   logic [25:0] data = '0;
   conv_ctl_t ctl;
   logic [39:0] cfg;
   int n_mismatch = 0;
   int compares = 0;
   int cyc = 0;
   int n_start = 0;
   int n_clr = 0;

   host_uart_model #(.P(P)) host (.clock_i(clock_i), .rx_o(rx), .tx_i(tx));
   adc_uart_readout #(.BIT_CYC(8)) DUT (.clock_i(clock_i),
      .arst_n_i(arst_n_i), .rx_i(rx), .tx_o(tx), .shared_flag_pin_o(pin),
      .shared_flag_pin_oe_o(pin_oe), .conv_done_i(done),
      .conv_busy_i(busy), .conv_data_i(data), .conv_ctl_o(ctl),
      .cfg_o(cfg));

   initial forever #20 clock_i = ~clock_i;

   task automatic finish_test();
      if (n_mismatch == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Whole run needs about 8000 cycles; ceiling leaves wide margin
   always @(posedge clock_i) begin
      cyc++;
      n_start += ctl.start;
      n_clr += ctl.filter_clear;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask

   task automatic cmd(input logic [7:0] b);
      host.send_byte(8'h55);
      host.send_byte(b);
      tick(4);
   endtask

   task automatic register_write_cmd(input logic [2:0] a, input logic [7:0] d);
      cmd({4'h4, a, 1'b0});
      host.send_byte(d);
      tick(4);
   endtask

   task automatic get(input int n, input logic [31:0] exp);
      logic [31:0] v;
      v = '0;
      for (int k = 0; k < 3000 && host.rxq.size() < n; k++)
         tick(1);
      for (int i = 0; i < n && host.rxq.size() > 0; i++)
         v[8*i +: 8] = host.rxq.pop_front();
      check(v, exp);
   endtask

   task automatic conv(input logic [25:0] d);
      done <= 1'b1;
      data <= d;
      tick(1);
      done <= 1'b0;
      tick(3);
   endtask

   initial begin
      logic [7:0] rexp [8];
      rexp = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h48, 8'h00, 8'h00, 8'h00};
      tick(5);
      arst_n_i <= 1'b1;
      tick(1);
      check({6'h0, pin_oe, tx, cfg}, {8'h01, 40'h0});
      busy <= 1'b1;
      register_write_cmd(3'h1, 8'h08);
      busy <= 1'b0;
      check({ctl.continuous, cfg[15:8]}, 9'h108);
      register_write_cmd(3'h4, 8'h48);
      check({n_start[7:0], n_clr[7:0], 6'h0, pin_oe, pin},
            24'h010103);
      register_write_cmd(3'h6, 8'hAA);
      check(cfg, 40'h4800000800);
      for (int a = 0; a < 8; a++) begin
         cmd({4'h2, 3'(a), 1'b0});
         get(1, rexp[a]);
      end
      check(host.rxq.size(), 0);
      conv(26'h0800000);
      check(pin, 1'b0);
      cmd(8'h25);
      get(1, 32'h80);
      cmd(8'h10);
      get(3, 32'h7FFFFF);
      check(pin, 1'b1);
      conv(26'h3700000);
      cmd(8'h1F);
      conv(26'h0000123);
      get(3, 32'h800000);
      check(pin, 1'b0);
      cmd(8'h10);
      get(3, 32'h000123);
      register_write_cmd(3'h2, 8'h40);
      register_write_cmd(3'h3, 8'h01);
      conv(26'h0000789);
      get(4, 32'h01000789);
      conv(26'h3FFFFFF);
      get(4, 32'h02FFFFFF);
      tick(P);
      busy <= 1'b1;
      cmd(8'h03);
      check(ctl.sleep, 1'b0);
      busy <= 1'b0;
      tick(3);
      check({ctl.sleep, cfg}, {1'b1, 40'h4801400800});
      cmd(8'h09);
      check({ctl.sleep, n_start[7:0], n_clr[7:0]}, 17'h00201);
      busy <= 1'b1;
      cmd(8'h08);
      busy <= 1'b0;
      check({n_start[7:0], n_clr[7:0]}, 16'h0302);
      cmd(8'h07);
      check({6'h0, pin_oe, tx, ctl, cfg}, {8'h01, 44'h0});
      check(host.rxq.size(), 0);
      tick(3);
      cmd(8'h22);
      get(1, 32'h00);
      finish_test();
   end
endmodule
`default_nettype wire
